// ---- bench/cds_dma_status_sva.sv ----
// Watches the bus and memory ports of the status block.
module cds_dma_status_sva
  import cds_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // APB port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cds_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Memory port.
  input wire cds_pkg::cds_mem_req_t memRequest,
  input wire cds_pkg::cds_mem_rsp_t memResponse,
  // Interrupt.
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // Completed reads of the status and the interrupt source words.
  wire logic statRead = pready && !pwrite && (paddr == OFF_STATUS);
  wire logic srcRead = pready && !pwrite && (paddr == OFF_INT_SOURCE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no ready after setup");
  a_status_gap_zero: assert property (statRead |-> prdata[23:22] == 2'h0)
    else $error("status gap bits set");
  a_src_upper_zero: assert property (srcRead |-> prdata[31:4] == 28'h0)
    else $error("source upper bits set");
  a_pending_or: assert property (srcRead |-> prdata[0] == (|prdata[3:1]))
    else $error("pending bit differs from flags");
  a_state_code_legal: assert property (statRead |-> prdata[21:18] <= CODE_SA)
    else $error("reserved state code");
  a_active_not_idle: assert property (statRead |-> prdata[16] == (prdata[21:18] != CODE_IDLE))
    else $error("active flag differs from state");
  a_start_with_active: assert property (statRead && prdata[16] |-> prdata[17])
    else $error("active without start");
  a_fault_drops_req: assert property (memResponse.err && memRequest.req |=> !memRequest.req)
    else $error("request kept after error");
  a_req_held: assert property (memRequest.req && !memResponse.ack && !memResponse.err
    |=> memRequest.req && $stable(memRequest.addr))
    else $error("request changed before answer");
endmodule

bind cds_dma_status cds_dma_status_sva u_sva (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .memRequest(memRequest),
  .memResponse(memResponse), .irq(irq));

// ---- bench/cds_dma_status_tb.sv ----
// Self-checking bench for the crypto descriptor DMA status block.
module cds_dma_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cds_pkg::*;

  // Clock, reset and bus request driven by the bench.
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  // Outputs of the block and the answer of the memory model.
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  cds_mem_req_t memRequest;
  cds_mem_rsp_t memResponse;
  // Memory model settings.
  logic [3:0] memWait = 4'h0;
  logic [31:0] faultAddr = 32'hFFFF_FFFC;
  // Counters and the last read answer.
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] rdData;
  logic rdErr;

  always #5 clk = ~clk;

  cds_dma_status u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memRequest(memRequest), .memResponse(memResponse), .irq(irq));
  cds_mem_model u_mem (.clk(clk), .reset(reset), .memRequest(memRequest),
    .memResponse(memResponse), .memWait(memWait), .faultAddr(faultAddr));

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge.
  task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Holds the request until pready is seen high at a rising edge; only the watchdog ends a hang.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    // The answer is taken at the very edge that completes the transfer.
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle, so the next request never lands in the same time step.
    @(posedge clk);
  endtask

  // Reads a word and compares it.
  task automatic rd_chk(input logic [APB_ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdData, exp);
  endtask

  // Reads a word until the masked bits match or the tries run out.
  task automatic poll(input logic [APB_ADDR_W-1:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rdData & m) !== exp && n < 100);
    check(rdData & m, exp);
  endtask

  // Checks the interrupt line once its registered update has landed.
  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge clk);
    check({31'h0, irq}, {31'h0, exp});
    @(posedge clk);
  endtask

  // Reset values, the read-only status word, base read-back and an unmapped address.
  task automatic t_regs();
    rd_chk(OFF_CHAIN_BASE, 32'h0);
    rd_chk(OFF_INT_SOURCE, 32'h0);
    apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
    rd_chk(OFF_STATUS, 32'h0);
    apb(1'b1, OFF_CHAIN_BASE, 32'hA5C3_0F3C);
    rd_chk(OFF_CHAIN_BASE, 32'hA5C3_0F3C);
    rd_chk(12'h020, 32'h0);
    check({31'h0, rdErr}, 32'h1);
  endtask

  // Two-descriptor chain on slow memory, with the global enable first left off.
  task automatic t_chain();
    u_mem.mem[16] = 32'h0000_A000;
    u_mem.mem[18] = 32'h1234_5678;
    u_mem.mem[20] = 32'h0000_C000;
    u_mem.mem[22] = 32'h9ABC_DEF0;
    memWait <= 4'h8;
    apb(1'b1, OFF_CHAIN_BASE, 32'h40);
    apb(1'b1, OFF_INT_ENABLE, 32'hE);
    // Fetch enabled but run enable clear: nothing may start.
    apb(1'b1, OFF_CONTROL, 32'h2);
    repeat (10) @(negedge clk);
    check({31'h0, memRequest.req}, 32'h0);
    @(posedge clk);
    rd_chk(OFF_STATUS, 32'h0);
    apb(1'b1, OFF_CONTROL, 32'h3);
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rdData & 32'h0003_0000, 32'h0003_0000);
    poll(OFF_INT_SOURCE, 32'hF, 32'h7);
    check(u_mem.mem[19], 32'h1234_5678);
    check(u_mem.mem[23], 32'h9ABC_DEF0);
    chk_irq(1'b0);
    apb(1'b1, OFF_INT_ENABLE, 32'hF);
    chk_irq(1'b1);
    apb(1'b1, OFF_INT_SOURCE, 32'hE);
    rd_chk(OFF_INT_SOURCE, 32'h0);
    chk_irq(1'b0);
  endtask

  // A disabled descriptor parks the processor until it is enabled in memory.
  task automatic t_refetch();
    int n;
    u_mem.mem[16] = 32'h0000_0123;
    memWait <= 4'h0;
    apb(1'b1, OFF_REFETCH_WAIT, 32'h14);
    apb(1'b1, OFF_CONTROL, 32'h3);
    poll(OFF_STATUS, 32'h003E_FFFF, 32'h0016_0123);
    // Times the quiet gap between two control-word reads: the programmed wait plus one.
    n = 0;
    while (memRequest.req !== 1'b1) @(posedge clk);
    while (memRequest.req === 1'b1) @(posedge clk);
    while (memRequest.req !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    check(n, 32'h0000_0015);
    u_mem.mem[16] = 32'h0000_C000;
    poll(OFF_INT_SOURCE, 32'h2, 32'h2);
    apb(1'b1, OFF_INT_SOURCE, 32'hE);
  endtask

  // A memory error in each phase, with modes 0 to 3 and operation codes 0, 1, 2 and 4.
  task automatic t_faults();
    logic [2:0] op;
    for (int i = 0; i < 4; i++) begin
      op = (i == 3) ? 3'h4 : 3'(i);
      apb(1'b1, OFF_CONTROL, 32'h4);
      apb(1'b1, OFF_INT_SOURCE, 32'hE);
      faultAddr <= 32'h40 + 32'(4 * i);
      u_mem.mem[16] = {16'h0, 5'h14, 3'(i), op, 5'h0};
      apb(1'b1, OFF_CONTROL, 32'h3);
      poll(OFF_INT_SOURCE, 32'hF, 32'h9);
      apb(1'b0, OFF_STATUS, 32'h0);
      check({24'h0, rdData[31:24]}, {24'h0, 3'(i), op, 2'(i)});
    end
    // A second error must not overwrite the first one's fields.
    apb(1'b1, OFF_INT_SOURCE, 32'hE);
    faultAddr <= 32'h44;
    apb(1'b1, OFF_CONTROL, 32'h3);
    poll(OFF_INT_SOURCE, 32'h8, 32'h8);
    apb(1'b0, OFF_STATUS, 32'h0);
    check({24'h0, rdData[31:24]}, 32'h73);
    apb(1'b1, OFF_CONTROL, 32'h4);
    rd_chk(OFF_STATUS, 32'h0);
  endtask

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence: reset for four cycles, then the scenarios.
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_chain();
    t_refetch();
    t_faults();
    close_out();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial begin
    #300000;
    error_cnt++;
    close_out();
  end
endmodule

// ---- bench/cds_mem_model.sv ----
// Behavioural system memory that answers the block's DMA requests.
module cds_mem_model
  import cds_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Request from the block and the answer to it.
  input wire cds_pkg::cds_mem_req_t memRequest,
  output cds_pkg::cds_mem_rsp_t memResponse,
  // Answer delay and the one address that answers with an error.
  input wire logic [3:0] memWait,
  input wire logic [31:0] faultAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Word storage; the bench loads descriptors here directly.
  logic [31:0] mem [0:63];
  // Cycles already waited on the present request.
  logic [3:0] waitCnt;
  // Word index of the requested address.
  wire logic [5:0] idx = memRequest.addr[7:2];

  initial memResponse = '0;

  // Answers each request once after memWait cycles, for one cycle only.
  always @(posedge clk) begin
    memResponse.ack <= 1'b0;
    memResponse.err <= 1'b0;
    // Read data is not held after the answer, so it toggles.
    memResponse.rdata <= ~memResponse.rdata;
    if (reset) begin
      waitCnt <= 4'h0;
      memResponse.rdata <= 32'h5A5A_5A5A;
    end else if (memRequest.req && !memResponse.ack && !memResponse.err) begin
      if (waitCnt != memWait) begin
        waitCnt <= waitCnt + 4'h1;
      end else begin
        waitCnt <= 4'h0;
        memResponse.err <= (memRequest.addr == faultAddr);
        memResponse.ack <= (memRequest.addr != faultAddr);
        if (memRequest.write && memRequest.addr != faultAddr) begin
          mem[idx] <= memRequest.wdata;
        end else begin
          memResponse.rdata <= mem[idx];
        end
      end
    end
  end
endmodule

// ---- hdl/cds_dma_status.sv ----
// Behaviour
// - Chain base register, 32-bit, read/write, resets zero.
// - Fetching starts at chain base once enabled.
// - Status 31-29 report fault mode.
// - Status 28-26 report failing operation.
// - Status 25-24 report DMA fault phase.
// - Status 21-18 show descriptor processor state.
// - Status 17 set once DMA started.
// - Status 16 set while processor active.
// - Status 15-0 mirror current control word.
// - Status 23-22 zero; status read-only, resets zero.
// - Source bit 3 set on memory error.
// - Source bit 2 set on packet completion.
// - Source bit 1 set after last descriptor.
// - Source bit 0 is OR of all.
// - Source bits 31-4 zero; resets zero.
// - DMA starts descriptors only while run enable set; one in work runs to its end.
// - Disabled descriptor refetched after programmed wait.
module cds_dma_status (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cds_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory master port of the DMA.
  output cds_pkg::cds_mem_req_t memRequest,
  input wire cds_pkg::cds_mem_rsp_t memResponse,
  // Interrupt output.
  output logic irq
);
  import cds_pkg::*;

  // Software-written control state.
  logic runEnable_reg; // DMA run enable.
  logic fetchEnable_reg; // Descriptor fetch enable, cleared by hardware at chain end.
  logic engineRst_reg; // One-cycle engine reset pulse.
  logic [31:0] chainBase_reg; // Address of the first descriptor.
  logic [3:0] intEnable_reg; // Individual enables and the global enable in bit 0.
  logic [15:0] refetchWait_reg; // Wait before refetching a disabled descriptor.

  // Descriptor processor state.
  cds_state_t state_reg;
  cds_state_t state_next;
  logic [31:0] descAddr_reg; // Address of the descriptor in work.
  logic [31:0] descAddr_next;
  logic [15:0] descCtrl_reg; // Control word of the descriptor in work.
  logic dstHalf_reg; // Low during the source read, high during the destination write.
  logic dstHalf_next;
  logic [31:0] dataWord_reg; // Source word carried to the destination.
  logic started_reg; // A DMA start has happened.

  // Captured fault information.
  logic [2:0] faultMode_reg;
  logic [2:0] faultOp_reg;
  logic [1:0] faultPhase_reg;
  logic faultHeld_reg; // Set once a fault has been captured.

  // Interrupt flags, bits 3 to 1 of the source register.
  logic [3:1] flags_reg;
  logic irq_reg;

  // Bus and memory output registers.
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  cds_mem_req_t memReq_reg;
  cds_mem_req_t memReq_next;

  // Address decode of the APB request.
  wire logic setupPhase = psel && !penable;
  wire logic writeTake = psel && penable && pready_reg && pwrite;
  wire logic hitControl = (paddr == OFF_CONTROL);
  wire logic hitBase = (paddr == OFF_CHAIN_BASE);
  wire logic hitStatus = (paddr == OFF_STATUS);
  wire logic hitSource = (paddr == OFF_INT_SOURCE);
  wire logic hitEnable = (paddr == OFF_INT_ENABLE);
  wire logic hitWait = (paddr == OFF_REFETCH_WAIT);
  wire logic mapped = hitControl || hitBase || hitStatus || hitSource || hitEnable || hitWait;

  // Memory access outcome for the request that is out.
  wire logic accessDone = memReq_reg.req && memResponse.ack && !memResponse.err;
  wire logic accessErr = memReq_reg.req && memResponse.err;
  wire logic runOk = runEnable_reg && fetchEnable_reg && !engineRst_reg;

  // Events raised in this cycle.
  wire logic doneState = (state_reg == ST_DONE);
  wire logic chainEnd = doneState && descCtrl_reg[DESC_LAST_BIT];
  wire logic [3:1] flagSet = {accessErr,
                              doneState && descCtrl_reg[DESC_PKT_END_BIT],
                              chainEnd};
  wire logic [3:1] flagClear = (writeTake && hitSource) ? pwdata[3:1] : 3'h0;
  wire logic [3:1] flags_next = (flags_reg & ~flagClear) | flagSet;
  wire logic anyPending = |flags_reg;
  wire logic irq_next = intEnable_reg[INT_PENDING_BIT] && |(flags_next & intEnable_reg[3:1]);

  // Refetch timer for disabled descriptors.
  wire logic waitArm = (state_reg == ST_WAIT);
  wire logic waitExpired;

  cds_refetch_timer #(
    .W(16)
  ) refetchTimer (
    .clk(clk),
    .reset(reset),
    .arm(waitArm),
    .cycles(refetchWait_reg),
    .expired(waitExpired)
  );

  // Reported state code of the descriptor processor.
  logic [3:0] stateCode;
  always_comb begin
    case (state_reg)
      ST_IDLE: stateCode = CODE_IDLE;
      ST_PEND: stateCode = CODE_PEND;
      ST_LOAD: stateCode = CODE_LOAD;
      ST_SA: stateCode = CODE_SA;
      ST_DATA: stateCode = CODE_DATA;
      ST_DONE: stateCode = CODE_DONE;
      ST_WAIT: stateCode = CODE_WAIT;
      default: stateCode = CODE_IDLE;
    endcase
  end

  // Phase of the access that is out, used when a fault is captured.
  logic [1:0] currentPhase;
  always_comb begin
    case (state_reg)
      ST_SA: currentPhase = PHASE_SA;
      ST_DATA: currentPhase = dstHalf_reg ? PHASE_DST : PHASE_SRC;
      default: currentPhase = PHASE_DESC;
    endcase
  end

  // Status word; bits 23-22 stay zero.
  wire logic [31:0] statusWord = {faultMode_reg,
                                  faultOp_reg,
                                  faultPhase_reg,
                                  2'b00,
                                  stateCode,
                                  started_reg,
                                  (state_reg != ST_IDLE),
                                  descCtrl_reg};
  wire logic [31:0] sourceWord = {28'h000_0000, flags_reg, anyPending};

  // Read data selection; unmapped addresses read zero.
  wire logic [31:0] readMux =
    hitControl ? {29'h0000_0000, engineRst_reg, fetchEnable_reg, runEnable_reg} :
    hitBase ? chainBase_reg :
    hitStatus ? statusWord :
    hitSource ? sourceWord :
    hitEnable ? {28'h000_0000, intEnable_reg} :
    hitWait ? {16'h0000, refetchWait_reg} :
    32'h0000_0000;

  // Next state of the descriptor processor.
  always_comb begin
    state_next = state_reg;
    descAddr_next = descAddr_reg;
    dstHalf_next = dstHalf_reg;
    case (state_reg)
      // Waits for run and fetch enable, then starts at the chain base.
      ST_IDLE: begin
        if (runOk) begin
          state_next = ST_PEND;
          descAddr_next = chainBase_reg;
        end
      end
      // A fetch is pending; the control word read is issued next.
      ST_PEND: begin
        state_next = runOk ? ST_LOAD : ST_IDLE;
      end
      // Reads the control word of the descriptor.
      ST_LOAD: begin
        if (accessErr) begin
          state_next = ST_IDLE;
        end else if (accessDone) begin
          if (memResponse.rdata[DESC_ENABLED_BIT]) begin
            state_next = ST_SA;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      // Reads the security association pointer.
      ST_SA: begin
        if (accessErr) begin
          state_next = ST_IDLE;
        end else if (accessDone) begin
          state_next = ST_DATA;
          dstHalf_next = 1'b0;
        end
      end
      // Reads the source word, then writes it to the destination.
      ST_DATA: begin
        if (accessErr) begin
          state_next = ST_IDLE;
        end else if (accessDone && !dstHalf_reg) begin
          dstHalf_next = 1'b1;
        end else if (accessDone) begin
          state_next = ST_DONE;
        end
      end
      // Descriptor finished; moves on unless it closed the chain or runOk is low.
      ST_DONE: begin
        if (descCtrl_reg[DESC_LAST_BIT] || !runOk) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_PEND;
          descAddr_next = descAddr_reg + DESC_STRIDE;
        end
      end
      // Descriptor was disabled; waits, then reads its control word again.
      ST_WAIT: begin
        if (!runOk) begin
          state_next = ST_IDLE;
        end else if (waitExpired) begin
          state_next = ST_LOAD;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Memory request that goes with the next state; it is held until answered.
  always_comb begin
    memReq_next = '0;
    case (state_next)
      ST_LOAD: begin
        memReq_next.req = 1'b1;
        memReq_next.addr = descAddr_next;
      end
      ST_SA: begin
        memReq_next.req = 1'b1;
        memReq_next.addr = descAddr_next + DESC_OFF_SA;
      end
      ST_DATA: begin
        memReq_next.req = 1'b1;
        memReq_next.write = dstHalf_next;
        memReq_next.addr = descAddr_next + (dstHalf_next ? DESC_OFF_DST : DESC_OFF_SRC);
        memReq_next.wdata = (accessDone && !dstHalf_reg) ? memResponse.rdata : dataWord_reg;
      end
      default: begin
        memReq_next = '0;
      end
    endcase
  end

  // APB answer: read data and error are prepared in the setup cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_reg <= RESET_WORD;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setupPhase;
      pslverr_reg <= setupPhase && !mapped;
      prdata_reg <= (setupPhase && !pwrite) ? readMux : RESET_WORD;
    end
  end

  // Software-written registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      runEnable_reg <= 1'b0;
      fetchEnable_reg <= 1'b0;
      engineRst_reg <= 1'b0;
      chainBase_reg <= RESET_WORD;
      intEnable_reg <= 4'h0;
      refetchWait_reg <= RESET_HALF;
    end else begin
      engineRst_reg <= writeTake && hitControl && pwdata[CTRL_ENGINE_RST_BIT];
      if (writeTake && hitControl) begin
        runEnable_reg <= pwdata[CTRL_RUN_BIT];
        fetchEnable_reg <= pwdata[CTRL_FETCH_BIT];
      end else if (chainEnd || accessErr) begin
        fetchEnable_reg <= 1'b0;
      end
      if (writeTake && hitBase) begin
        chainBase_reg <= pwdata;
      end
      if (writeTake && hitEnable) begin
        intEnable_reg <= pwdata[3:0];
      end
      if (writeTake && hitWait) begin
        refetchWait_reg <= pwdata[15:0];
      end
    end
  end

  // Descriptor processor registers; the engine reset returns them to idle.
  always_ff @(posedge clk) begin
    if (reset || engineRst_reg) begin
      state_reg <= ST_IDLE;
      descAddr_reg <= RESET_WORD;
      descCtrl_reg <= RESET_HALF;
      dstHalf_reg <= 1'b0;
      dataWord_reg <= RESET_WORD;
      started_reg <= 1'b0;
      memReq_reg <= '0;
    end else begin
      state_reg <= state_next;
      descAddr_reg <= descAddr_next;
      dstHalf_reg <= dstHalf_next;
      memReq_reg <= memReq_next;
      if (state_reg == ST_LOAD && accessDone) begin
        descCtrl_reg <= memResponse.rdata[15:0];
      end
      if (state_reg == ST_DATA && accessDone && !dstHalf_reg) begin
        dataWord_reg <= memResponse.rdata;
      end
      if (state_reg == ST_IDLE && runOk) begin
        started_reg <= 1'b1;
      end
    end
  end

  // Fault capture keeps the first fault until reset or engine reset.
  always_ff @(posedge clk) begin
    if (reset || engineRst_reg) begin
      faultMode_reg <= 3'h0;
      faultOp_reg <= 3'h0;
      faultPhase_reg <= 2'h0;
      faultHeld_reg <= 1'b0;
    end else if (accessErr && !faultHeld_reg) begin
      faultMode_reg <= descCtrl_reg[DESC_MODE_LSB +: 3];
      faultOp_reg <= descCtrl_reg[DESC_OP_LSB +: 3];
      faultPhase_reg <= currentPhase;
      faultHeld_reg <= 1'b1;
    end
  end

  // Sticky interrupt flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      irq_reg <= irq_next;
    end
  end

  // Outputs come straight from registers.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign memRequest = memReq_reg;
  assign irq = irq_reg;
endmodule

// ---- hdl/cds_pkg.sv ----
// Shared constants and types for the crypto descriptor DMA status block.
package cds_pkg;

  // APB address width and data width.
  localparam int APB_ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets on APB.
  localparam logic [APB_ADDR_W-1:0] OFF_CONTROL = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFF_CHAIN_BASE = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 12'h008;
  localparam logic [APB_ADDR_W-1:0] OFF_INT_SOURCE = 12'h00C;
  localparam logic [APB_ADDR_W-1:0] OFF_INT_ENABLE = 12'h010;
  localparam logic [APB_ADDR_W-1:0] OFF_REFETCH_WAIT = 12'h014;

  // Reset values.
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] RESET_HALF = 16'h0000;

  // Control register bit positions.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FETCH_BIT = 1;
  localparam int CTRL_ENGINE_RST_BIT = 2;

  // Status register field positions.
  localparam int STAT_MODE_LSB = 29;
  localparam int STAT_OP_LSB = 26;
  localparam int STAT_PHASE_LSB = 24;
  localparam int STAT_STATE_LSB = 18;
  localparam int STAT_START_BIT = 17;
  localparam int STAT_ACTIVE_BIT = 16;

  // Interrupt source and enable bit positions.
  localparam int INT_PENDING_BIT = 0;
  localparam int INT_LAST_BIT = 1;
  localparam int INT_PACKET_BIT = 2;
  localparam int INT_ACCESS_BIT = 3;

  // Descriptor control word fields.
  localparam int DESC_ENABLED_BIT = 15;
  localparam int DESC_LAST_BIT = 14;
  localparam int DESC_PKT_END_BIT = 13;
  localparam int DESC_MODE_LSB = 8;
  localparam int DESC_OP_LSB = 5;

  // Byte offsets of the words inside one descriptor, and the spacing of descriptors.
  localparam logic [31:0] DESC_OFF_SA = 32'h0000_0004;
  localparam logic [31:0] DESC_OFF_SRC = 32'h0000_0008;
  localparam logic [31:0] DESC_OFF_DST = 32'h0000_000C;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;

  // Reported state codes of the descriptor processor.
  localparam logic [3:0] CODE_IDLE = 4'h0;
  localparam logic [3:0] CODE_PEND = 4'h1;
  localparam logic [3:0] CODE_LOAD = 4'h2;
  localparam logic [3:0] CODE_DATA = 4'h3;
  localparam logic [3:0] CODE_DONE = 4'h4;
  localparam logic [3:0] CODE_WAIT = 4'h5;
  localparam logic [3:0] CODE_SA = 4'h6;

  // Error phase codes.
  localparam logic [1:0] PHASE_DESC = 2'h0;
  localparam logic [1:0] PHASE_SA = 2'h1;
  localparam logic [1:0] PHASE_SRC = 2'h2;
  localparam logic [1:0] PHASE_DST = 2'h3;

  // One-hot states of the descriptor processor.
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_PEND = 7'b000_0010,
    ST_LOAD = 7'b000_0100,
    ST_SA = 7'b000_1000,
    ST_DATA = 7'b001_0000,
    ST_DONE = 7'b010_0000,
    ST_WAIT = 7'b100_0000
  } cds_state_t;

  // Memory request issued by the DMA.
  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cds_mem_req_t;

  // Memory answer to one request.
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } cds_mem_rsp_t;

endpackage

// ---- hdl/cds_refetch_timer.sv ----
// Counts the programmed number of cycles while armed, then pulses expired once.
module cds_refetch_timer #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Control.
  input wire logic arm,
  input wire logic [W-1:0] cycles,
  // Result.
  output logic expired
);
  import cds_pkg::*;

  logic [W-1:0] count_reg; // Cycles spent armed so far.
  logic expired_reg; // One-cycle pulse when the wait is over.

  // A programmed count of zero still waits one cycle.
  wire logic [W-1:0] limit = (cycles == '0) ? W'(1) : cycles;
  wire logic hit = arm && !expired_reg && (count_reg == limit - W'(1));

  // The counter restarts whenever the timer is not armed.
  always_ff @(posedge clk) begin
    if (reset || !arm) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_reg + W'(1);
      expired_reg <= hit;
    end
  end

  assign expired = expired_reg;
endmodule
